/* dsg_clock_gating.sv */
`timescale 1ns/10ps
module dsg_clock_gating
    import dsg_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Power mode from the core, same clock.
    input wire logic sleep_i,
    input wire logic deep_sleep_i,
    // Access strobes toward each controlled unit, same clock.
    input wire logic phy_access_i,
    input wire logic mac_access_i,
    input wire logic [DSG_PORT_N-1:0] port_access_i,
    // Clock enables of the controlled units.
    output logic phy_clock_enable_o,
    output logic mac_clock_enable_o,
    output logic [DSG_PORT_N-1:0] port_clock_enable_o,
    // Bus fault pulse and interrupt.
    output logic unit_fault_o,
    output logic irq_o
);

    // Whole state of the block outside the three gating registers.
    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
        logic [31:0] cfg;
        logic [1:0] stat;
        logic [1:0] mask;
        dsg_mode_type mode;
        logic phy_en;
        logic mac_en;
        logic [DSG_PORT_N-1:0] port_en;
        logic fault;
    } dsg_state_type;

    dsg_state_type s_q; // Registered state.
    dsg_state_type s_d; // Next state.

    logic req; // A bus cycle is being presented.
    logic in_space; // Address lies in the system control space.
    logic [11:0] offset; // Offset inside that space.
    logic mapped; // Offset names a register of this block.
    logic commit; // Write takes effect at this edge.
    logic [31:0] lane_mask; // Bits covered by the selected byte lanes.
    logic we_run; // Write strobe of the run-mode gating register.
    logic we_sleep; // Write strobe of the sleep-mode gating register.
    logic we_deep; // Write strobe of the deep-sleep gating register.
    logic [31:0] run_q; // Run-mode gating register.
    logic [31:0] sleep_q; // Sleep-mode gating register.
    logic [31:0] deep_q; // Deep-sleep gating register.
    logic [31:0] gate_sel; // Gating word in force for the next cycle.
    logic [31:0] rd_val; // Read value for the addressed register.
    logic fault_now; // Some unit is accessed while unclocked.
    logic [1:0] events; // Interrupt events of this cycle.

    // Address decode; the low two address bits are ignored since every register is a word.
    always_comb
    begin
        req = wb_cyc_i & wb_stb_i;
        in_space = (wb_adr_i[31:DSG_OFF_W] == DSG_BASE_ADDR[31:DSG_OFF_W]);
        offset = {wb_adr_i[11:2], 2'b00};
        mapped = 1'b0;
        if (in_space)
        begin
            case (offset)
                DSG_CFG_OFF, DSG_RUN_OFF, DSG_SLEEP_OFF, DSG_DEEP_OFF, DSG_STAT_OFF, DSG_MASK_OFF:
                begin
                    mapped = 1'b1;
                end
                default:
                begin
                    mapped = 1'b0;
                end
            endcase
        end
    end

    // A write is applied only at the edge on which ack is already high, so the
    // master sees it take effect exactly when it samples the answer.
    always_comb
    begin
        commit = s_q.ack & req & wb_we_i;
        lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        we_run = commit & (offset == DSG_RUN_OFF);
        we_sleep = commit & (offset == DSG_SLEEP_OFF);
        we_deep = commit & (offset == DSG_DEEP_OFF);
    end

    // The three gating registers are kept apart, one per power mode.
    dsg_gate_reg #(
        .WMASK(DSG_GATE_WMASK),
        .RESET(DSG_GATE_RESET)
    ) u_run_clock_gate_2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(we_run),
        .sel_i(wb_sel_i),
        .wdat_i(wb_dat_i),
        .q_o(run_q)
    );

    dsg_gate_reg #(
        .WMASK(DSG_GATE_WMASK),
        .RESET(DSG_GATE_RESET)
    ) u_sleep_clock_gate_2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(we_sleep),
        .sel_i(wb_sel_i),
        .wdat_i(wb_dat_i),
        .q_o(sleep_q)
    );

    dsg_gate_reg #(
        .WMASK(DSG_GATE_WMASK),
        .RESET(DSG_GATE_RESET)
    ) u_deep_sleep_clock_gate_2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(we_deep),
        .sel_i(wb_sel_i),
        .wdat_i(wb_dat_i),
        .q_o(deep_q)
    );

    // Read multiplexer; unmapped offsets read zero but are answered with err.
    always_comb
    begin
        case (offset)
            DSG_CFG_OFF:
            begin
                rd_val = s_q.cfg;
            end
            DSG_RUN_OFF:
            begin
                rd_val = run_q;
            end
            DSG_SLEEP_OFF:
            begin
                rd_val = sleep_q;
            end
            DSG_DEEP_OFF:
            begin
                rd_val = deep_q;
            end
            DSG_STAT_OFF:
            begin
                rd_val = {30'h0000_0000, s_q.stat};
            end
            DSG_MASK_OFF:
            begin
                rd_val = {30'h0000_0000, s_q.mask};
            end
            default:
            begin
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // Pick the gating word for the mode; without automatic gating the run word always wins.
    always_comb
    begin
        gate_sel = run_q;
        if (s_q.cfg[DSG_AUTO_BIT])
        begin
            case (s_q.mode)
                DSG_MODE_SLEEP:
                begin
                    gate_sel = sleep_q;
                end
                DSG_MODE_DEEP:
                begin
                    gate_sel = deep_q;
                end
                default:
                begin
                    gate_sel = run_q;
                end
            endcase
        end
    end

    // A unit touched while its clock is off would hang the bus, so the access is faulted instead.
    always_comb
    begin
        fault_now = (phy_access_i & ~s_q.phy_en) | (mac_access_i & ~s_q.mac_en)
            | (|(port_access_i & ~s_q.port_en));
        events = 2'b00;
        events[DSG_IRQ_FAULT_BIT] = fault_now;
        events[DSG_IRQ_DEEP_BIT] = deep_sleep_i & (s_q.mode != DSG_MODE_DEEP);
    end

    // Next-state logic of the bus answer, configuration, interrupts and clock enables.
    always_comb
    begin
        s_d = s_q;
        // Answer one cycle after the request; ack is dropped right after it was given.
        s_d.ack = req & ~s_q.ack & ~s_q.err & mapped;
        s_d.err = req & ~s_q.ack & ~s_q.err & ~mapped;
        if (req & ~s_q.ack & ~s_q.err)
        begin
            s_d.rdata = rd_val;
        end
        if (commit & (offset == DSG_CFG_OFF))
        begin
            s_d.cfg = (s_q.cfg & ~(lane_mask & DSG_CFG_WMASK)) | (wb_dat_i & lane_mask & DSG_CFG_WMASK);
        end
        if (commit & (offset == DSG_MASK_OFF) & wb_sel_i[0])
        begin
            s_d.mask = wb_dat_i[1:0];
        end
        // Write one clears; an event in the same cycle sets, so it is never lost.
        if (commit & (offset == DSG_STAT_OFF) & wb_sel_i[0])
        begin
            s_d.stat = (s_q.stat & ~wb_dat_i[1:0]) | events;
        end
        else
        begin
            s_d.stat = s_q.stat | events;
        end
        // Deep sleep takes priority over plain sleep.
        if (deep_sleep_i)
        begin
            s_d.mode = DSG_MODE_DEEP;
        end
        else if (sleep_i)
        begin
            s_d.mode = DSG_MODE_SLEEP;
        end
        else
        begin
            s_d.mode = DSG_MODE_RUN;
        end
        s_d.phy_en = gate_sel[DSG_PHY_BIT];
        s_d.mac_en = gate_sel[DSG_MAC_BIT];
        s_d.port_en = gate_sel[DSG_PORT_LSB +: DSG_PORT_N];
        s_d.fault = fault_now;
    end

    // State register; reset leaves every unit unclocked.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q.ack <= 1'b0;
            s_q.err <= 1'b0;
            s_q.rdata <= 32'h0000_0000;
            s_q.cfg <= DSG_CFG_RESET;
            s_q.stat <= DSG_IRQ_RESET;
            s_q.mask <= DSG_IRQ_RESET;
            s_q.mode <= DSG_MODE_RUN;
            s_q.phy_en <= 1'b0;
            s_q.mac_en <= 1'b0;
            s_q.port_en <= '0;
            s_q.fault <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs; the enables are registered so that a gate never glitches.
    assign wb_ack_o = s_q.ack;
    assign wb_err_o = s_q.err;
    assign wb_dat_o = s_q.rdata;
    assign phy_clock_enable_o = s_q.phy_en;
    assign mac_clock_enable_o = s_q.mac_en;
    assign port_clock_enable_o = s_q.port_en;
    assign unit_fault_o = s_q.fault;
    assign irq_o = |(s_q.stat & s_q.mask);

    // Checks of the behaviour above.
    default clocking dsg_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_after_req: assert property ((req && !wb_ack_o && !wb_err_o && mapped) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("mapped request not acknowledged in one cycle");

    a_err_unmapped: assert property ((req && !wb_ack_o && !wb_err_o && !mapped) |=> wb_err_o && !wb_ack_o)
        else $error("unmapped request not answered with err");

    a_deep_phy_mac: assert property ((s_q.mode == DSG_MODE_DEEP && s_q.cfg[DSG_AUTO_BIT])
        |=> phy_clock_enable_o == $past(deep_q[30]) && mac_clock_enable_o == $past(deep_q[28]))
        else $error("deep sleep enables do not follow the deep gating word");

    a_deep_ports: assert property ((s_q.mode == DSG_MODE_DEEP && s_q.cfg[DSG_AUTO_BIT])
        |=> port_clock_enable_o == $past(deep_q[6:0]))
        else $error("deep sleep port enables wrong");

    a_no_auto_run: assert property ((!s_q.cfg[DSG_AUTO_BIT])
        |=> mac_clock_enable_o == $past(run_q[28]) && port_clock_enable_o == $past(run_q[6:0]))
        else $error("run word not applied without automatic gating");

    a_fault_gated: assert property ((phy_access_i && !phy_clock_enable_o) |=> unit_fault_o ##0 s_q.stat[0])
        else $error("access to unclocked unit not faulted");

    a_no_fault_open: assert property ((!fault_now) |=> !unit_fault_o)
        else $error("fault raised with all accessed units clocked");

    a_deep_rsvd_zero: assert property ((wb_ack_o && !$past(wb_we_i) && $past(offset) == DSG_DEEP_OFF)
        |-> (wb_dat_o & ~DSG_GATE_WMASK) == 32'h0000_0000)
        else $error("reserved bits of deep gating read nonzero");

    a_reset_clear: assert property ($past(rst_i) |-> deep_q == 32'h0000_0000 && !phy_clock_enable_o)
        else $error("gating not cleared by reset");

    // The sleep word must govern the ports whenever automatic gating is on in sleep.
    a_sleep_word: assert property ((s_q.mode == DSG_MODE_SLEEP && s_q.cfg[DSG_AUTO_BIT])
        |=> port_clock_enable_o == $past(sleep_q[6:0]))
        else $error("sleep port enables do not follow the sleep gating word");

    // Entering deep sleep is recorded in the sticky status, even during a clear.
    a_deep_event: assert property ((deep_sleep_i && s_q.mode != DSG_MODE_DEEP)
        |=> s_q.stat[DSG_IRQ_DEEP_BIT])
        else $error("deep sleep entry not recorded in status");

    c_deep_fault: cover property (s_q.mode == DSG_MODE_DEEP ##1 unit_fault_o);
    c_deep_write: cover property (we_deep ##1 !wb_ack_o);
    c_irq_raise: cover property (!irq_o ##1 irq_o);
    c_auto_sleep: cover property (s_q.mode == DSG_MODE_SLEEP && s_q.cfg[DSG_AUTO_BIT]);

endmodule

/* dsg_pkg.sv */
// Shared constants and types of the deep-sleep clock gating block.
package dsg_pkg;

    // Base of the system control space; only the upper address bits are compared.
    localparam logic [31:0] DSG_BASE_ADDR = 32'h400F_E000;
    localparam int unsigned DSG_OFF_W = 12;

    // Register offsets inside the system control space.
    localparam logic [11:0] DSG_CFG_OFF = 12'h060;
    localparam logic [11:0] DSG_RUN_OFF = 12'h108;
    localparam logic [11:0] DSG_SLEEP_OFF = 12'h118;
    localparam logic [11:0] DSG_DEEP_OFF = 12'h128;
    localparam logic [11:0] DSG_STAT_OFF = 12'h200;
    localparam logic [11:0] DSG_MASK_OFF = 12'h204;

    // Gating register layout: writable bits and reset value.
    localparam logic [31:0] DSG_GATE_WMASK = 32'h5000_007F;
    localparam logic [31:0] DSG_GATE_RESET = 32'h0000_0000;
    localparam int unsigned DSG_PHY_BIT = 30;
    localparam int unsigned DSG_MAC_BIT = 28;
    localparam int unsigned DSG_PORT_LSB = 0;
    localparam int unsigned DSG_PORT_N = 7;

    // Run-mode clock configuration: only the automatic gating select bit is held here.
    localparam int unsigned DSG_AUTO_BIT = 27;
    localparam logic [31:0] DSG_CFG_WMASK = 32'h0800_0000;
    localparam logic [31:0] DSG_CFG_RESET = 32'h0000_0000;

    // Interrupt status and mask layout.
    localparam int unsigned DSG_IRQ_FAULT_BIT = 0;
    localparam int unsigned DSG_IRQ_DEEP_BIT = 1;
    localparam logic [1:0] DSG_IRQ_RESET = 2'h0;

    // Power mode that the core is currently in.
    typedef enum logic [1:0] {
        DSG_MODE_RUN,
        DSG_MODE_SLEEP,
        DSG_MODE_DEEP
    } dsg_mode_type;

endpackage

/* dsg_gate_reg.sv */
`timescale 1ns/10ps
// One 32-bit software register with byte lanes; bits outside the write mask hold zero.
module dsg_gate_reg
    import dsg_pkg::*;
#(
    parameter logic [31:0] WMASK = DSG_GATE_WMASK,
    parameter logic [31:0] RESET = DSG_GATE_RESET
)
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Write strobe with byte lanes and data.
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] wdat_i,
    // Stored value.
    output logic [31:0] q_o
);

    // Whole state of this register.
    typedef struct packed {
        logic [31:0] value;
    } dsg_reg_state_type;

    dsg_reg_state_type s_q; // Registered state.
    dsg_reg_state_type s_d; // Next state.
    logic [31:0] lane_mask; // Writable bits covered by the selected byte lanes.

    // Only masked bits of selected lanes change; reserved bits never leave zero.
    always_comb
    begin
        s_d = s_q;
        lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}} & WMASK;
        if (we_i)
        begin
            s_d.value = (s_q.value & ~lane_mask) | (wdat_i & lane_mask);
        end
    end

    // Synchronous reset loads the documented reset value.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q.value <= RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign q_o = s_q.value;

endmodule

/* tb.sv */
`timescale 1ns/10ps
// Self-checking bench for the deep-sleep clock gating block.
module tb;
    import dsg_pkg::*;
    // Stimulus driven into the block, all given values at time zero.
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0000_0000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic sleep_i = 1'b0;
    logic deep_sleep_i = 1'b0;
    logic phy_access_i = 1'b0;
    logic mac_access_i = 1'b0;
    logic [DSG_PORT_N-1:0] port_access_i = 7'h00;
    // Observed outputs.
    logic [31:0] wb_dat_o;
    logic wb_ack_o, wb_err_o, phy_clock_enable_o, mac_clock_enable_o, unit_fault_o, irq_o;
    logic [DSG_PORT_N-1:0] port_clock_enable_o;
    // Enables gathered as PHY, MAC, then ports G down to A.
    wire logic [8:0] en = {phy_clock_enable_o, mac_clock_enable_o, port_clock_enable_o};
    // Scoreboard counters and the cycle count for the hang guard.
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;

    dsg_clock_gating u_dsg_clock_gating (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sleep_i(sleep_i), .deep_sleep_i(deep_sleep_i),
        .phy_access_i(phy_access_i), .mac_access_i(mac_access_i), .port_access_i(port_access_i),
        .phy_clock_enable_o(phy_clock_enable_o), .mac_clock_enable_o(mac_clock_enable_o),
        .port_clock_enable_o(port_clock_enable_o), .unit_fault_o(unit_fault_o), .irq_o(irq_o));

    // The 100 MHz clock.
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    // Hang guard: the whole run needs a few hundred cycles, so this ceiling is generous.
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Compares one value with its expectation; case equality keeps unknowns from matching.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One classic bus cycle; the request is held until ack or err is sampled high.
    task automatic bus(input logic we, input logic [11:0] off, input logic [3:0] sel, input logic [31:0] dat,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        wb_adr_i <= {DSG_BASE_ADDR[31:12], off};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        err = wb_err_o;
        chk("bus latency", n, 32'h0000_0002);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    // Full-word write and checked read helpers.
    task automatic wr(input logic [11:0] off, input logic [31:0] dat);
        logic [31:0] r;
        logic e;
        bus(1'b1, off, 4'hF, dat, r, e);
    endtask

    task automatic rdchk(input string name, input logic [11:0] off, input logic [31:0] msk, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        bus(1'b0, off, 4'hF, 32'h0000_0000, r, e);
        chk(name, r & msk, exp);
    endtask

    // Word that governs the enables: the run word unless automatic gating picks a sleep word.
    function automatic logic [8:0] exp_en(logic [31:0] rw, logic [31:0] sw, logic [31:0] dw, logic au,
                                          logic slp, logic dp);
        logic [31:0] w;
        w = !au ? rw : (dp ? dw : (slp ? sw : rw));
        return {w[DSG_PHY_BIT], w[DSG_MAC_BIT], w[6:0]};
    endfunction

    // Main sequence.
    initial
    begin
        logic [31:0] rw, sw, dw, r;
        logic [8:0] acc;
        logic au, e;
        logic [11:0] offs [3];
        int seed, u;
        offs = '{DSG_RUN_OFF, DSG_SLEEP_OFF, DSG_DEEP_OFF};
        seed = $urandom(72244);
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk("enables after reset", {23'h0, en}, 32'h0000_0000);
        chk("irq after reset", {31'h0, irq_o}, 32'h0000_0000);
        foreach (offs[i])
            rdchk("gate reset", offs[i], 32'hFFFF_FFFF, DSG_GATE_RESET);
        rdchk("config reset", DSG_CFG_OFF, 32'hFFFF_FFFF, 32'h0000_0000);
        // Random words land only in the writable bits of every gating register.
        for (int k = 0; k < 6; k++)
        begin
            foreach (offs[i])
            begin
                rw = (k == 0) ? 32'hFFFF_FFFF : $urandom();
                wr(offs[i], rw);
                rdchk("gate word", offs[i], 32'hFFFF_FFFF, rw & 32'h5000_007F);
            end
        end
        // A single top lane of ones after clearing touches only the PHY and MAC bits.
        wr(DSG_DEEP_OFF, 32'h0000_0000);
        bus(1'b1, DSG_DEEP_OFF, 4'h8, 32'hFFFF_FFFF, r, e);
        rdchk("top lane", DSG_DEEP_OFF, 32'hFFFF_FFFF, 32'h5000_0000);
        // An unmapped neighbour is refused and leaves the deep word alone.
        bus(1'b1, 12'h12C, 4'hF, 32'h0000_007F, r, e);
        chk("unmapped err", {31'h0, e}, 32'h0000_0001);
        rdchk("deep kept", DSG_DEEP_OFF, 32'hFFFF_FFFF, 32'h5000_0000);
        // Read-modify-write that keeps every other bit as it was read.
        bus(1'b0, DSG_DEEP_OFF, 4'hF, 32'h0000_0000, r, e);
        wr(DSG_DEEP_OFF, r | 32'h0000_0001);
        rdchk("rmw keeps", DSG_DEEP_OFF, 32'hFFFF_FFFF, 32'h5000_0001);
        // Random words, automatic gating and power modes pick the enables; accesses fault when gated.
        for (int k = 0; k < 16; k++)
        begin
            rw = $urandom();
            sw = $urandom();
            dw = $urandom();
            au = (k < 2) ? k[0] : 1'($urandom_range(1));
            wr(DSG_RUN_OFF, rw);
            wr(DSG_SLEEP_OFF, sw);
            wr(DSG_DEEP_OFF, dw);
            wr(DSG_CFG_OFF, {4'h0, au, 27'h0});
            @(posedge clk_i);
            sleep_i <= (k < 2) ? 1'b1 : 1'($urandom_range(1));
            deep_sleep_i <= (k < 2) ? 1'b1 : 1'($urandom_range(1));
            repeat (2) @(posedge clk_i);
            #1;
            chk("enables", {23'h0, en}, {23'h0, exp_en(rw, sw, dw, au, sleep_i, deep_sleep_i)});
            chk("enables", {23'h0, en}, {23'h0, exp_en(rw, sw, dw, au, sleep_i, deep_sleep_i)});
            u = $urandom_range(8);
            acc = 9'h001 << u;
            @(posedge clk_i);
            {phy_access_i, mac_access_i, port_access_i} <= acc;
            @(posedge clk_i);
            {phy_access_i, mac_access_i, port_access_i} <= 9'h000;
            #1;
            chk("fault", {31'h0, unit_fault_o}, {31'h0, ~en[u]});
        end
        // Awake with everything gated: a PHY access must fault, then the interrupt path is walked.
        @(posedge clk_i);
        sleep_i <= 1'b0;
        deep_sleep_i <= 1'b0;
        wr(DSG_CFG_OFF, 32'h0000_0000);
        wr(DSG_RUN_OFF, 32'h0000_0000);
        wr(DSG_MASK_OFF, 32'h0000_0000);
        rdchk("deep entry", DSG_STAT_OFF, 32'h0000_0002, 32'h0000_0002);
        wr(DSG_STAT_OFF, 32'h0000_0003);
        @(posedge clk_i);
        phy_access_i <= 1'b1;
        @(posedge clk_i);
        phy_access_i <= 1'b0;
        #1;
        chk("phy fault", {31'h0, unit_fault_o}, 32'h0000_0001);
        rdchk("status fault", DSG_STAT_OFF, 32'h0000_0001, 32'h0000_0001);
        chk("irq masked", {31'h0, irq_o}, 32'h0000_0000);
        wr(DSG_MASK_OFF, 32'h0000_0001);
        @(posedge clk_i);
        #1;
        chk("irq raised", {31'h0, irq_o}, 32'h0000_0001);
        wr(DSG_STAT_OFF, 32'h0000_0003);
        @(posedge clk_i);
        #1;
        chk("irq cleared", {31'h0, irq_o}, 32'h0000_0000);
        rdchk("status cleared", DSG_STAT_OFF, 32'h0000_0001, 32'h0000_0000);
        // Software enables the PHY before touching it, so the access is served.
        wr(DSG_RUN_OFF, 32'h4000_0000);
        @(posedge clk_i);
        phy_access_i <= 1'b1;
        @(posedge clk_i);
        phy_access_i <= 1'b0;
        #1;
        chk("phy enabled", {31'h0, unit_fault_o}, 32'h0000_0000);
        report_and_stop();
    end
endmodule
